// *** src/dso_status_outputs.sv ***
// Status outputs, fault words and storage commands of a servo drive.
// Assumes cfg, meas, faults and the parameter port come from logic on clk;
// limit and index inputs come from pins and are synchronised here.
`timescale 1ns/1ps
`include "dso_params.svh"
// Contract
// - Position reached after window held long enough
// - Zero speed after velocity window time
// - Speed reached while error below window
// - Torque mode: speed limit reached flag
// - Torque limit after exceeding filter time
// - Zero baseline disables torque limit output
// - Brake output active releases the lock
// - Ready when drive may be enabled
// - Enabled while power stage holds shaft
// - Position limited on either travel limit
// - Index output on encoder index pulse
// - Write 1 stores, 10 initialises configuration
// - Configuration store excludes motor parameters
// - Motor store command saves motor parameters
// - First fault word read-only, resets 0408
// - First fault word bits 0 to 7
// - First fault word bits 8 to 15
// - Second word bits 0-4, 5-7 reserved
// - Second fault word bits 8 to 15
module dso_status_outputs import dso_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `DSO_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration and live quantities
  input wire dso_cfg_t cfg,
  input wire dso_meas_t meas,
  input wire dso_fault1_t fault1_in,
  input wire dso_fault2_t fault2_in,
  // Pins
  input wire logic lim_pos_pin,
  input wire logic lim_neg_pin,
  input wire logic index_pin,
  // Parameter port
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata_q,
  output logic par_rvalid_q,
  // Nonvolatile store handshake
  input wire logic nv_done,
  output logic nv_store_cfg_q,
  output logic nv_init_cfg_q,
  output logic nv_store_motor_q,
  // Digital output functions
  output dso_do_t do_q
);

  // ---------------------------------------------------------------
  // Pin synchronisers and index edge
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic idx_prev_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      idx_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {index_pin, lim_neg_pin, lim_pos_pin};
      pin_s2_q <= pin_s1_q;
      idx_prev_q <= pin_s2_q[2];
    end
  end

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic [17:0] div_q;
  logic [17:0] div_d;
  logic tick_d;
  logic tick_q;

  always_comb begin
    tick_d = (div_q == 18'(TICK_CYCLES - 1));
    div_d = tick_d ? 18'h00000 : div_q + 18'h00001;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= 18'h00000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // Window conditions
  // ---------------------------------------------------------------
  logic [31:0] pos_err_abs;
  logic [31:0] vel_abs;
  logic [31:0] vel_err_abs;
  logic [15:0] tq_abs;
  logic pos_cond;
  logic zero_cond;
  logic spd_cond;
  logic lim_cond;
  logic tq_cond;
  logic pos_qual;
  logic zero_qual;
  logic tq_qual;

  always_comb begin
    pos_err_abs = meas.pos_error[31] ? 32'(-meas.pos_error) : meas.pos_error;
    vel_abs = meas.vel_actual[31] ? 32'(-meas.vel_actual) : meas.vel_actual;
    vel_err_abs = meas.vel_error[31] ? 32'(-meas.vel_error) : meas.vel_error;
    tq_abs = meas.torque_actual[15] ? 16'(-meas.torque_actual) : meas.torque_actual;
    pos_cond = meas.pos_mode && (pos_err_abs < cfg.pos_window);
    zero_cond = (vel_abs <= cfg.zero_vel_window);
    spd_cond = (vel_err_abs < cfg.speed_window);
    lim_cond = meas.torque_mode && (vel_abs >= cfg.max_speed);
    // Zero baseline would match any torque, so it means detection off
    tq_cond = (cfg.torque_base != 16'h0000) && (tq_abs >= cfg.torque_base);
  end

  dso_qualifier u_pos_qual (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .limit(cfg.pos_win_ms),
    .strict(1'b0),
    .cond(pos_cond),
    .qual_q(pos_qual)
  );

  dso_qualifier u_zero_qual (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .limit(cfg.zero_vel_ms),
    .strict(1'b0),
    .cond(zero_cond),
    .qual_q(zero_qual)
  );

  // Strict compare: the time must be exceeded, not merely met
  dso_qualifier u_tq_qual (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .limit(cfg.torque_filt_ms),
    .strict(1'b1),
    .cond(tq_cond),
    .qual_q(tq_qual)
  );

  // ---------------------------------------------------------------
  // Fault words
  // ---------------------------------------------------------------
  dso_fault1_t f1_q;
  dso_fault1_t f1_d;
  dso_fault2_t f2_q;
  dso_fault2_t f2_d;

  always_comb begin
    f1_d = fault1_in;
    f2_d = fault2_in;
    f2_d.reserved = 3'h0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      f1_q <= `DSO_FAULT1_RST;
      f2_q <= `DSO_FAULT2_RST;
    end else begin
      f1_q <= f1_d;
      f2_q <= f2_d;
    end
  end

  // ---------------------------------------------------------------
  // Output functions
  // ---------------------------------------------------------------
  dso_do_t do_d;

  always_comb begin
    do_d.error = (|f1_q) || (|f2_q);
    do_d.ready = meas.drive_ready && !do_d.error;
    do_d.pos_reached = pos_qual;
    do_d.zero_speed = zero_qual;
    do_d.brake_release = meas.power_enabled;
    do_d.speed_reached = spd_cond;
    do_d.index_seen = pin_s2_q[2] && !idx_prev_q;
    do_d.speed_limit = lim_cond;
    do_d.enabled = meas.power_enabled;
    do_d.pos_limited = pin_s2_q[0] || pin_s2_q[1];
    do_d.home_found = meas.home_found;
    do_d.torque_limit = tq_qual;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      do_q <= '0;
    end else begin
      do_q <= do_d;
    end
  end

  // ---------------------------------------------------------------
  // Storage commands
  // ---------------------------------------------------------------
  dso_nv_state_t nv_q;
  dso_nv_state_t nv_d;
  logic [7:0] cfg_cmd_q;
  logic [7:0] cfg_cmd_d;
  logic [7:0] mot_cmd_q;
  logic [7:0] mot_cmd_d;
  logic st_cfg_d;
  logic in_cfg_d;
  logic st_mot_d;
  logic cfg_wr;
  logic mot_wr;

  always_comb begin
    nv_d = nv_q;
    cfg_cmd_d = cfg_cmd_q;
    mot_cmd_d = mot_cmd_q;
    st_cfg_d = 1'b0;
    in_cfg_d = 1'b0;
    st_mot_d = 1'b0;
    cfg_wr = par_wr && (par_addr == `DSO_ADDR_CFG_STORE);
    mot_wr = par_wr && (par_addr == `DSO_ADDR_MOT_STORE);
    unique case (nv_q)
      DSO_NV_IDLE: begin
        // A new command only starts here; writes while busy are dropped
        if (cfg_wr) begin
          cfg_cmd_d = par_wdata[7:0];
          st_cfg_d = (par_wdata[7:0] == `DSO_CMD_STORE);
          in_cfg_d = (par_wdata[7:0] == `DSO_CMD_INIT);
        end else if (mot_wr) begin
          mot_cmd_d = par_wdata[7:0];
          st_mot_d = (par_wdata[7:0] == `DSO_CMD_STORE);
        end
        if (st_cfg_d || in_cfg_d || st_mot_d) begin
          nv_d = DSO_NV_BUSY;
        end
      end
      DSO_NV_BUSY: begin
        if (nv_done) begin
          nv_d = DSO_NV_IDLE;
          cfg_cmd_d = `DSO_CMD_RST;
          mot_cmd_d = `DSO_CMD_RST;
        end
      end
      default: begin
        nv_d = DSO_NV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nv_q <= DSO_NV_IDLE;
      cfg_cmd_q <= `DSO_CMD_RST;
      mot_cmd_q <= `DSO_CMD_RST;
      nv_store_cfg_q <= 1'b0;
      nv_init_cfg_q <= 1'b0;
      nv_store_motor_q <= 1'b0;
    end else begin
      nv_q <= nv_d;
      cfg_cmd_q <= cfg_cmd_d;
      mot_cmd_q <= mot_cmd_d;
      nv_store_cfg_q <= st_cfg_d;
      nv_init_cfg_q <= in_cfg_d;
      nv_store_motor_q <= st_mot_d;
    end
  end

  // ---------------------------------------------------------------
  // Parameter reads
  // ---------------------------------------------------------------
  logic [15:0] rdata_d;

  always_comb begin
    unique case (par_addr)
      `DSO_ADDR_FAULT1: rdata_d = f1_q;
      `DSO_ADDR_FAULT2: rdata_d = f2_q;
      `DSO_ADDR_CFG_STORE: rdata_d = {8'h00, cfg_cmd_q};
      `DSO_ADDR_MOT_STORE: rdata_d = {8'h00, mot_cmd_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      par_rdata_q <= 16'h0000;
      par_rvalid_q <= 1'b0;
    end else begin
      par_rdata_q <= par_rd ? rdata_d : 16'h0000;
      par_rvalid_q <= par_rd;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pos_needs_cond: assert property (@(posedge clk) disable iff (sys_rst)
    do_q.pos_reached |-> $past(pos_cond, 2)) else $error("position reached without window");

  a_zero_needs_cond: assert property (@(posedge clk) disable iff (sys_rst)
    do_q.zero_speed |-> $past(zero_cond, 2)) else $error("zero speed without window");

  a_speed_follows: assert property (@(posedge clk) disable iff (sys_rst)
    spd_cond |=> do_q.speed_reached) else $error("speed reached missed");

  a_torque_off: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg.torque_base == 16'h0000) [*3] |-> !do_q.torque_limit)
    else $error("torque limit with zero baseline");

  a_error_any: assert property (@(posedge clk) disable iff (sys_rst)
    ((|f1_q) || (|f2_q)) |=> do_q.error) else $error("error output missed fault");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    f2_q.reserved == 3'h0) else $error("reserved fault bits set");

  a_store_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    (nv_q == DSO_NV_IDLE && cfg_wr && par_wdata[7:0] == `DSO_CMD_INIT) |=>
    (nv_init_cfg_q && !nv_store_cfg_q && nv_q == DSO_NV_BUSY))
    else $error("init command not issued");

  a_limit_out: assert property (@(posedge clk) disable iff (sys_rst)
    (pin_s2_q[0] || pin_s2_q[1]) |=> do_q.pos_limited) else $error("limit output missed");

endmodule : dso_status_outputs

// *** src/dso_params.svh ***
// Constants of the drive status output block: offsets, codes, reset values, timing.
// Assumes inclusion by the design files and the bench by bare name.
`ifndef DSO_PARAMS_SVH
`define DSO_PARAMS_SVH

// ---------------------------------------------------------------
// Parameter addresses
// ---------------------------------------------------------------
`define DSO_ADDR_FAULT1 16'h1F00
`define DSO_ADDR_FAULT2 16'h2000
`define DSO_ADDR_CFG_STORE 16'h2910
`define DSO_ADDR_MOT_STORE 16'h2930

// ---------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------
`define DSO_FAULT1_RST 16'h0408
`define DSO_FAULT2_RST 16'h0000
`define DSO_FAULT2_RSVD 16'h00E0
`define DSO_CMD_RST 8'h00

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define DSO_CMD_STORE 8'h01
`define DSO_CMD_INIT 8'h0A

// ---------------------------------------------------------------
// Timing: qualifying times count in milliseconds
// ---------------------------------------------------------------
`define DSO_TICK_NS 1000000
`define DSO_CLK_NS 5
`define DSO_TICK_CYCLES (`DSO_TICK_NS / `DSO_CLK_NS)

`endif

// *** src/dso_pkg.sv ***
// Types of the drive status output block.
// Assumes dso_params.svh holds the numeric constants.
package dso_pkg;

  // ---------------------------------------------------------------
  // Configuration from the parameter store
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] pos_window;
    logic [15:0] pos_win_ms;
    logic [31:0] zero_vel_window;
    logic [15:0] zero_vel_ms;
    logic [31:0] speed_window;
    logic [31:0] max_speed;
    logic [15:0] torque_base;
    logic [15:0] torque_filt_ms;
  } dso_cfg_t;

  // ---------------------------------------------------------------
  // Live quantities from the control loops
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pos_mode;
    logic torque_mode;
    logic signed [31:0] pos_error;
    logic signed [31:0] vel_actual;
    logic signed [31:0] vel_error;
    logic signed [15:0] torque_actual;
    logic drive_ready;
    logic power_enabled;
    logic home_found;
  } dso_meas_t;

  // ---------------------------------------------------------------
  // First fault word, bit 15 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic nv_data;
    logic commutation;
    logic motor_temp;
    logic over_freq;
    logic current_time_overload;
    logic low_logic_supply;
    logic following;
    logic chopper;
    logic over_current;
    logic under_voltage;
    logic over_voltage;
    logic drive_temp;
    logic enc_count;
    logic enc_commutation;
    logic enc_wiring;
    logic extended;
  } dso_fault1_t;

  // ---------------------------------------------------------------
  // Second fault word, bit 15 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic master_count;
    logic master_enc;
    logic loop_direction;
    logic aborted_link;
    logic serial_link;
    logic neg_limit;
    logic pos_limit;
    logic ext_enable;
    logic [2:0] reserved;
    logic motor_config;
    logic processor_identity_check;
    logic spurious_irq;
    logic watchdog;
    logic current_sensor;
  } dso_fault2_t;

  // ---------------------------------------------------------------
  // Digital output functions
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic error;
    logic pos_reached;
    logic zero_speed;
    logic brake_release;
    logic speed_reached;
    logic index_seen;
    logic speed_limit;
    logic enabled;
    logic pos_limited;
    logic home_found;
    logic torque_limit;
  } dso_do_t;

  typedef enum logic [1:0] {
    DSO_NV_IDLE = 2'b01,
    DSO_NV_BUSY = 2'b10
  } dso_nv_state_t;

endpackage : dso_pkg

// *** src/dso_qualifier.sv ***
// Duration qualifier: a condition must hold for a number of millisecond ticks.
// Assumes tick is a one-cycle enable on clk.
`timescale 1ns/1ps
`include "dso_params.svh"
module dso_qualifier import dso_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Timing
  input wire logic tick,
  input wire logic [15:0] limit,
  input wire logic strict,
  // Condition and result
  input wire logic cond,
  output logic qual_q
);

  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic qual_d;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    qual_d = 1'b0;
    if (!cond) begin
      cnt_d = 17'h00000;
    end else begin
      if (tick && !cnt_q[16]) begin
        cnt_d = cnt_q + 17'h00001;
      end
      // Saturation at 2^16 keeps any 16-bit limit reachable
      // One tick past the limit: the first tick may land at once
      qual_d = (cnt_q > {1'b0, limit}) || (!strict && (limit == 16'h0000));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 17'h00000;
      qual_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      qual_q <= qual_d;
    end
  end

  a_qual_restart: assert property (@(posedge clk) disable iff (sys_rst)
    !cond |=> !qual_q) else $error("qualifier held while condition false");

endmodule : dso_qualifier

// *** test/dso_nv_model.sv ***
// Stand-in for the nonvolatile store behind the status block.
// Assumes one request pulse at a time; lat sets the write time.
`timescale 1ns/1ps
module dso_nv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request and answer
  input wire logic req,
  input wire logic [7:0] lat,
  output logic nv_done
);
  logic [7:0] cnt_q;
  logic busy_q;
  // Done is a single pulse, so a stuck level cannot hide a second command
  always_ff @(posedge clk) begin
    nv_done <= 1'b0;
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (req) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'b0;
      nv_done <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : dso_nv_model

// *** test/tb_top.sv ***
// Self-checking bench of the drive status output block.
// Assumes a short tick of 4 cycles and the store model in dso_nv_model.
`timescale 1ns/1ps
`include "dso_params.svh"
module tb_top import dso_pkg::*; ;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int D_RDY = 11, D_ERR = 10, D_POS = 9, D_ZERO = 8, D_BRK = 7, D_SPD = 6;
  localparam int D_IDX = 5, D_LIM = 4, D_EN = 3, D_PLIM = 2, D_HOME = 1, D_TRQ = 0;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  dso_cfg_t cfg;
  dso_meas_t meas;
  dso_fault1_t f1;
  dso_fault2_t f2;
  dso_do_t dq;
  logic [11:0] dv;
  logic lp, ln, ix, wr, rd, rv, done, sc, ic, sm;
  logic [15:0] addr, wd, rdata;
  logic [7:0] lat;
  int mismatches = 0;
  int num_checks = 0;
  assign dv = dq;
  always #2.5 clk = ~clk;
  dso_status_outputs #(.TICK_CYCLES(4)) u_dso_status_outputs (.clk(clk), .sys_rst(sys_rst),
    .cfg(cfg), .meas(meas), .fault1_in(f1), .fault2_in(f2), .lim_pos_pin(lp),
    .lim_neg_pin(ln), .index_pin(ix), .par_wr(wr), .par_rd(rd), .par_addr(addr),
    .par_wdata(wd), .par_rdata_q(rdata), .par_rvalid_q(rv), .nv_done(done),
    .nv_store_cfg_q(sc), .nv_init_cfg_q(ic), .nv_store_motor_q(sm), .do_q(dq));
  dso_nv_model u_dso_nv_model (.clk(clk), .sys_rst(sys_rst), .req(sc | ic | sm),
    .lat(lat), .nv_done(done));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_bit(input int b, input logic v, input int n, input string msg);
    int i;
    #1;
    for (i = 0; i < n && dv[b] !== v; i++) cyc(1);
    check(dv[b] === v, msg);
  endtask : wait_bit
  // Early look catches a qualifier that ignores its time
  task automatic qual_chk(input int b, input int lo, input int hi, input string msg);
    cyc(lo);
    check(dv[b] === 1'b0, msg);
    wait_bit(b, 1'b1, hi - lo, msg);
  endtask : qual_chk
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rv === 1'b1, "read valid missing");
    d = rdata;
  endtask : rd_reg
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic wait_done;
    int i;
    for (i = 0; i < 60 && done !== 1'b1; i++) cyc(1);
    check(done === 1'b1, "store never finished");
    cyc(2);
  endtask : wait_done
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_faults;
    logic [15:0] d;
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      f1 <= 16'h0001 << i;
      f2 <= 16'h0001 << i;
      cyc(3);
      check(dv[D_ERR] === 1'b1, "error output low");
      rd_reg(`DSO_ADDR_FAULT1, d);
      check(d === 16'h0001 << i, "fault word 1 bit");
      rd_reg(`DSO_ADDR_FAULT2, d);
      check(d === ((16'h0001 << i) & ~`DSO_FAULT2_RSVD), "fault word 2 bit");
    end
    wr_reg(`DSO_ADDR_FAULT1, 16'h00FF);
    rd_reg(`DSO_ADDR_FAULT1, d);
    check(d === 16'h8000, "fault word 1 written");
    @(posedge clk);
    f1 <= 16'h0000;
    f2 <= `DSO_FAULT2_RSVD;
    cyc(3);
    check(dv[D_ERR] === 1'b0, "error with no fault");
  endtask : t_faults
  task automatic t_cmds;
    logic [15:0] d;
    lat <= 8'h10;
    wr_reg(`DSO_ADDR_CFG_STORE, 16'h0001);
    check({sc, ic, sm} === 3'b100, "config store pulse");
    wr_reg(`DSO_ADDR_MOT_STORE, 16'h0001);
    check(sm === 1'b0, "command taken while busy");
    rd_reg(`DSO_ADDR_CFG_STORE, d);
    check(d === 16'h0001, "store command readback");
    wait_done();
    lat <= 8'h00;
    wr_reg(`DSO_ADDR_CFG_STORE, 16'h000A);
    check({sc, ic, sm} === 3'b010, "config init pulse");
    wait_done();
    wr_reg(`DSO_ADDR_CFG_STORE, 16'h0002);
    check({sc, ic, sm} === 3'b000, "odd code started a store");
    wr_reg(`DSO_ADDR_MOT_STORE, 16'h0001);
    check({sc, ic, sm} === 3'b001, "motor store pulse");
    wait_done();
    rd_reg(`DSO_ADDR_MOT_STORE, d);
    check(d === 16'h0000, "motor command not cleared");
  endtask : t_cmds
  task automatic t_levels;
    @(posedge clk);
    meas.drive_ready <= 1'b1;
    meas.power_enabled <= 1'b1;
    meas.home_found <= 1'b1;
    meas.torque_mode <= 1'b1;
    meas.vel_actual <= -32'sd500;
    meas.vel_error <= 32'sd100;
    cfg.speed_window <= 32'd100;
    cfg.max_speed <= 32'd500;
    cyc(2);
    check(dv[D_RDY] === 1'b1, "ready low");
    check(dv[D_EN] === 1'b1 && dv[D_HOME] === 1'b1, "enabled low");
    check(dv[D_BRK] === 1'b1, "brake not released");
    check(dv[D_SPD] === 1'b0, "speed reached at window");
    check(dv[D_LIM] === 1'b1, "speed limit low");
    @(posedge clk);
    meas.vel_error <= -32'sd99;
    meas.torque_mode <= 1'b0;
    meas.drive_ready <= 1'b0;
    meas.power_enabled <= 1'b0;
    cyc(2);
    check(dv[D_SPD] === 1'b1, "speed reached low");
    check(dv[D_LIM] === 1'b0, "speed limit outside torque mode");
    check(dv[D_BRK] === 1'b0 && dv[D_EN] === 1'b0, "brake or enable stuck");
    check(dv[D_RDY] === 1'b0, "ready stuck");
  endtask : t_levels
  task automatic t_pins;
    @(posedge clk);
    lp <= 1'b1;
    wait_bit(D_PLIM, 1'b1, 5, "positive limit missed");
    @(posedge clk);
    lp <= 1'b0;
    ln <= 1'b1;
    cyc(5);
    check(dv[D_PLIM] === 1'b1, "negative limit missed");
    @(posedge clk);
    ln <= 1'b0;
    wait_bit(D_PLIM, 1'b0, 5, "limit output stuck");
    @(posedge clk);
    ix <= 1'b1;
    @(posedge clk);
    ix <= 1'b0;
    wait_bit(D_IDX, 1'b1, 5, "index missed");
    cyc(1);
    check(dv[D_IDX] === 1'b0, "index not a pulse");
  endtask : t_pins
  task automatic t_qual;
    @(posedge clk);
    cfg.pos_window <= 32'd100;
    cfg.pos_win_ms <= 16'h0002;
    meas.pos_mode <= 1'b1;
    meas.pos_error <= -32'sd99;
    qual_chk(D_POS, 8, 14, "position reached timing");
    @(posedge clk);
    meas.pos_error <= 32'sd100;
    wait_bit(D_POS, 1'b0, 3, "position reached held");
    @(posedge clk);
    meas.pos_error <= 32'sd0;
    qual_chk(D_POS, 8, 14, "position timer not restarted");
    @(posedge clk);
    meas.pos_mode <= 1'b0;
    wait_bit(D_POS, 1'b0, 3, "position reached outside mode");
    @(posedge clk);
    cfg.zero_vel_window <= 32'd10;
    cfg.zero_vel_ms <= 16'h0003;
    meas.vel_actual <= -32'sd10;
    qual_chk(D_ZERO, 12, 18, "zero speed timing");
    @(posedge clk);
    cfg.torque_base <= 16'h0032;
    cfg.torque_filt_ms <= 16'h0001;
    meas.torque_actual <= -16'sd50;
    qual_chk(D_TRQ, 4, 14, "torque limit timing");
    @(posedge clk);
    cfg.torque_base <= 16'h0000;
    cyc(20);
    check(dv[D_TRQ] === 1'b0, "torque limit with zero baseline");
  endtask : t_qual
  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    cfg = '0;
    meas = '0;
    meas.pos_error = 32'sd1000;
    f1 = '0;
    f2 = '0;
    {lp, ln, ix, wr, rd} = 5'h00;
    addr = 16'h0000;
    wd = 16'h0000;
    lat = 8'h08;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(1);
    // Fault word still holds its reset value here, so error shows once
    check(dv === 12'h400, "error missing after reset");
    cyc(1);
    check(dv === 12'h100, "outputs after reset");
    t_faults();
    t_cmds();
    t_levels();
    t_pins();
    t_qual();
    conclude();
  end
  // Tests take a few hundred cycles; this limit leaves ample margin
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule : tb_top
